// *** drg_read_gate.sv ***
// Contract
// - Raise read gate anywhere on the track, then watch the deserializer bits.
// - Drop read gate when the supposed preamble yields no address mark.
// - No built-in on/off retry cycling; separator or external logic supplies it; here the gate drops and reraises itself after every miss.
// - All-zero stream aborts the command after two index pulses, sector not found.
// - Drop read gate when a one passes the deserializer without pattern match.
// - Hold read gate low about 18 bits; separator resyncs meanwhile.
// - Start-with-address-mark format uses a no-transition gap as the mark.
// - Write data goes out serially in NRZ, timed by the write clock.
// - Shared clock is reference while gate inactive, read clock once synced.
// - Write clock runs at bit rate, following the read/reference clock.
// - Write clock keeps running throughout the write window.
// - Data and clock use four point-to-point pairs, never multiplexed.
// - Missed mark: drop gate 19 read clocks after first one, reraise 17.5 later.
//
// Purpose: Read gate and NRZ write path of a disk data controller
// Assumes: nrz_rdata_in is timed by rclk_in; config inputs are stable while busy
// Notes: wclk_out is rclk_in forwarded, so it runs whenever the link clock does
`timescale 1ns/100ps
`include "drg_regs.svh"
module drg_read_gate (
    // System clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Link clock from the drive
    input wire logic rclk_in,
    // Command side
    input wire logic start_in,
    input wire logic sam_mode_in,
    input wire logic [7:0] first_pattern_in,
    input wire logic [7:0] sync_byte_in,
    output logic busy_out,
    output logic found_out,
    output logic sect_not_found_out,
    // Write command side
    input wire logic write_en_in,
    input wire logic wr_load_in,
    input wire logic [7:0] wr_byte_in,
    output logic wr_ready_out,
    // Drive and separator pins
    input wire logic index_in,
    input wire logic mark_found_input_in,
    input wire logic nrz_rdata_in,
    output logic rd_gate_out,
    output logic wr_gate_out,
    output logic nrz_wdata_out,
    output logic wclk_out
);

    // ****************************************
    // Shared signals
    // ****************************************
    localparam logic [4:0] PAT_CYC = 5'(`DRG_DESER_BITS);
    localparam logic [4:0] DROP_CYC = 5'(`DRG_AM_DROP_RCLK);
    localparam logic [4:0] REGATE_CYC = 5'(`DRG_REGATE_CYC);
    localparam logic [1:0] IDX_ABORT = 2'(`DRG_INDEX_ABORT_COUNT);

    logic link_rst_n;
    logic index_s;
    logic index_d1_q;
    logic search_q;
    logic search_s;
    logic found_tgl_q;
    logic found_tgl_s;
    logic found_seen_q;
    logic wr_req_tgl_q;
    logic wr_req_s;
    logic wr_ack_tgl_q;
    logic wr_ack_s;
    logic wr_en_s;
    logic mark_s;
    logic [7:0] pattern_q;
    logic [7:0] sync_q;
    logic sam_q;
    logic [7:0] wr_hold_q;
    drg_pkg::drg_cmd_state_t cmd_q;
    logic [1:0] idx_cnt_q;
    logic found_ev;
    logic idx_rise;

    // ****************************************
    // Crossings
    // ****************************************
    drg_sync #(.WIDTH(1)) u_link_rst (
        .clk_in(rclk_in),
        .resetn_in(1'b1),
        .d_in(resetn_in),
        .q_out(link_rst_n)
    );

    drg_sync #(.WIDTH(3)) u_to_sys (
        .clk_in(clk_sys_in),
        .resetn_in(resetn_in),
        .d_in({index_in, found_tgl_q, wr_ack_tgl_q}),
        .q_out({index_s, found_tgl_s, wr_ack_s})
    );

    drg_sync #(.WIDTH(4)) u_to_link (
        .clk_in(rclk_in),
        .resetn_in(link_rst_n),
        .d_in({search_q, wr_req_tgl_q, write_en_in, mark_found_input_in}),
        .q_out({search_s, wr_req_s, wr_en_s, mark_s})
    );

    assign found_ev = found_tgl_s != found_seen_q;
    assign idx_rise = index_s && !index_d1_q;

    // ****************************************
    // Command sequencing, system clock
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            index_d1_q <= 1'b0;
            found_seen_q <= 1'b0;
        end else begin
            index_d1_q <= index_s;
            found_seen_q <= found_tgl_s;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            cmd_q <= drg_pkg::CMD_IDLE;
            search_q <= 1'b0;
            busy_out <= 1'b0;
            found_out <= 1'b0;
            sect_not_found_out <= 1'b0;
            idx_cnt_q <= 2'h0;
            pattern_q <= `DRG_SHIFT_RESET;
            sync_q <= `DRG_SHIFT_RESET;
            sam_q <= 1'b0;
        end else begin
            case (cmd_q)
                drg_pkg::CMD_IDLE: begin
                    if (start_in) begin
                        cmd_q <= drg_pkg::CMD_SEARCH;
                        search_q <= 1'b1;
                        busy_out <= 1'b1;
                        found_out <= 1'b0;
                        sect_not_found_out <= 1'b0;
                        idx_cnt_q <= 2'h0;
                        pattern_q <= first_pattern_in;
                        sync_q <= sync_byte_in;
                        sam_q <= sam_mode_in;
                    end
                end
                drg_pkg::CMD_SEARCH: begin
                    if (found_ev) begin
                        cmd_q <= drg_pkg::CMD_IDLE;
                        search_q <= 1'b0;
                        busy_out <= 1'b0;
                        found_out <= 1'b1;
                    end else if (idx_rise) begin
                        if (idx_cnt_q == IDX_ABORT - 2'h1) begin
                            cmd_q <= drg_pkg::CMD_IDLE;
                            search_q <= 1'b0;
                            busy_out <= 1'b0;
                            sect_not_found_out <= 1'b1;
                        end
                        idx_cnt_q <= idx_cnt_q + 2'h1;
                    end
                end
                default: begin
                    cmd_q <= drg_pkg::CMD_IDLE;
                    search_q <= 1'b0;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    // Write byte handshake; byte stays put until the link acknowledges
    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            wr_req_tgl_q <= 1'b0;
            wr_hold_q <= `DRG_WR_IDLE_BYTE;
            wr_ready_out <= 1'b1;
        end else if (wr_load_in && wr_ready_out) begin
            wr_req_tgl_q <= !wr_req_tgl_q;
            wr_hold_q <= wr_byte_in;
            wr_ready_out <= 1'b0;
        end else if (!wr_ready_out && wr_ack_s == wr_req_tgl_q) begin
            wr_ready_out <= 1'b1;
        end
    end

    // ****************************************
    // Read gate, link clock
    // ****************************************
    drg_pkg::drg_gate_state_t rg_q;
    logic [7:0] shift_q;
    logic [4:0] cnt_q;
    logic mark_seen_q;
    logic miss_q;
    logic match_now;

    // Pattern, sync byte and mode are frozen while search_s is high
    assign match_now = shift_q == pattern_q;

    always_ff @(posedge rclk_in) begin
        if (!link_rst_n) begin
            shift_q <= `DRG_SHIFT_RESET;
        end else if (rd_gate_out) begin
            shift_q <= {shift_q[6:0], nrz_rdata_in};
        end else begin
            shift_q <= `DRG_SHIFT_RESET;
        end
    end

    always_ff @(posedge rclk_in) begin
        if (!link_rst_n) begin
            rg_q <= drg_pkg::RG_OFF;
            rd_gate_out <= 1'b0;
            cnt_q <= 5'h00;
            mark_seen_q <= 1'b0;
            miss_q <= 1'b0;
            found_tgl_q <= 1'b0;
        end else if (!search_s) begin
            rg_q <= drg_pkg::RG_OFF;
            rd_gate_out <= 1'b0;
        end else begin
            case (rg_q)
                drg_pkg::RG_OFF: begin
                    rg_q <= drg_pkg::RG_ZERO;
                    rd_gate_out <= 1'b1;
                end
                drg_pkg::RG_ZERO: begin
                    mark_seen_q <= 1'b0;
                    miss_q <= 1'b0;
                    if (nrz_rdata_in) begin
                        rg_q <= drg_pkg::RG_NZ;
                        cnt_q <= 5'h01;
                    end
                end
                drg_pkg::RG_NZ: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (mark_s) begin
                        mark_seen_q <= 1'b1;
                    end
                    if (cnt_q == PAT_CYC) begin
                        if (match_now && (sam_q || mark_seen_q || mark_s)) begin
                            rg_q <= drg_pkg::RG_SYNC;
                        end else begin
                            miss_q <= 1'b1;
                        end
                    end
                    if (miss_q && cnt_q == DROP_CYC - 5'h01) begin
                        rg_q <= drg_pkg::RG_HOLD;
                        rd_gate_out <= 1'b0;
                        cnt_q <= 5'h01;
                    end
                end
                // gate held while synced, then parked low until the search ends
                drg_pkg::RG_SYNC: begin
                    if (rd_gate_out && shift_q == sync_q) begin
                        found_tgl_q <= !found_tgl_q;
                        rd_gate_out <= 1'b0;
                    end
                end
                drg_pkg::RG_HOLD: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == REGATE_CYC) begin
                        rg_q <= drg_pkg::RG_ZERO;
                        rd_gate_out <= 1'b1;
                    end
                end
                default: begin
                    rg_q <= drg_pkg::RG_OFF;
                    rd_gate_out <= 1'b0;
                end
            endcase
        end
    end

    // reraise repeats after every miss until the search ends
    // A hung separator that never sends a one is caught only above.

    // ****************************************
    // Write path, link clock
    // ****************************************
    logic [7:0] wsh_q;
    logic [2:0] wbit_q;
    logic wr_seen_q;

    assign wclk_out = rclk_in;

    always_ff @(posedge rclk_in) begin
        if (!link_rst_n) begin
            wr_gate_out <= 1'b0;
            nrz_wdata_out <= 1'b0;
            wsh_q <= `DRG_WR_IDLE_BYTE;
            wbit_q <= 3'h0;
            wr_seen_q <= 1'b0;
            wr_ack_tgl_q <= 1'b0;
        end else begin
            wr_gate_out <= wr_en_s;
            if (!wr_gate_out) begin
                nrz_wdata_out <= 1'b0;
                wbit_q <= 3'h0;
            end else begin
                nrz_wdata_out <= wsh_q[7];
                wbit_q <= wbit_q + 3'h1;
            end
            // Byte waits in the holding register until the window opens, so none is lost
            if ((wr_gate_out ? wbit_q == 3'h7 : wr_en_s) && wr_req_s != wr_seen_q) begin
                wsh_q <= wr_hold_q;
                wr_seen_q <= wr_req_s;
                wr_ack_tgl_q <= wr_req_s;
            end else if (wbit_q == 3'h7 || !wr_gate_out) begin
                // Underrun sends zeroes rather than repeating stale data
                wsh_q <= `DRG_WR_IDLE_BYTE;
            end else begin
                wsh_q <= {wsh_q[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    localparam int HOLD_MAX = 20;

    a_gate_rises_search: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        (search_s && rg_q == drg_pkg::RG_OFF) |=> rd_gate_out)
        else $error("read gate did not rise on search");

    a_gate_off_idle: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        !search_s |=> !rd_gate_out)
        else $error("read gate high without search");

    a_miss_drop_time: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        (rg_q == drg_pkg::RG_ZERO && search_s && nrz_rdata_in) ##8
        (search_s && rg_q == drg_pkg::RG_NZ && cnt_q == PAT_CYC && !match_now) ##1
        search_s[*8] |=> ((rd_gate_out || !search_s)[*2] ##1 !rd_gate_out))
        else $error("gate not dropped 19 clocks after first one");

    a_hold_min_off: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        ($fell(rd_gate_out) && rg_q == drg_pkg::RG_HOLD) |->
        (!rd_gate_out[*8] ##1 !rd_gate_out[*8] ##1 !rd_gate_out[*2]))
        else $error("read gate off time too short");

    a_hold_bounded: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        (rg_q == drg_pkg::RG_HOLD) |-> ##[1:HOLD_MAX] (rg_q != drg_pkg::RG_HOLD))
        else $error("read gate never reraised");

    a_sam_accepts: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        (search_s && rg_q == drg_pkg::RG_NZ && cnt_q == PAT_CYC && match_now && sam_q)
        |=> (rg_q == drg_pkg::RG_SYNC || !search_s))
        else $error("pattern match refused in start-with-mark mode");

    a_mismatch_flags: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        (search_s && rg_q == drg_pkg::RG_NZ && cnt_q == PAT_CYC && !match_now)
        |=> (miss_q || !search_s))
        else $error("mismatch not recorded");

    a_wdata_serial: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        wr_gate_out |=> (nrz_wdata_out == $past(wsh_q[7])))
        else $error("write data not taken from shifter");

    a_wdata_idle_zero: assert property (@(posedge rclk_in) disable iff (!link_rst_n)
        !wr_gate_out |=> !nrz_wdata_out)
        else $error("write data active outside write window");

    a_abort_two_idx: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (cmd_q == drg_pkg::CMD_SEARCH && !found_ev && idx_rise && idx_cnt_q == 2'h1)
        |=> (sect_not_found_out && !busy_out))
        else $error("search not aborted at second index");

    c_abort: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) $rose(sect_not_found_out));
    c_found: cover property (@(posedge clk_sys_in) disable iff (!resetn_in) $rose(found_out));
    c_regate: cover property (@(posedge rclk_in) disable iff (!link_rst_n)
        (rg_q == drg_pkg::RG_HOLD) ##1 (rg_q == drg_pkg::RG_ZERO));
    c_write_byte: cover property (@(posedge rclk_in) disable iff (!link_rst_n)
        wr_gate_out && wr_req_s != wr_seen_q && wbit_q == 3'h7);

endmodule // drg_read_gate

// *** drg_regs.svh ***
// Purpose: Timing and field constants for the read gate supervisor
// Assumes: Link counts are in read/reference clock periods
// Notes: Definitions only
`ifndef DRG_REGS_SVH
`define DRG_REGS_SVH

// ****************************************
// Read gate timing, in read clocks
// ****************************************
`define DRG_DESER_BITS 8
`define DRG_AM_DROP_RCLK 19
`define DRG_REGATE_TENTHS_RCLK 175
// Least time rounds up to whole read clocks
`define DRG_REGATE_CYC ((`DRG_REGATE_TENTHS_RCLK + 9) / 10)

// ****************************************
// Command timing
// ****************************************
`define DRG_INDEX_ABORT_COUNT 2

// ****************************************
// Reset values
// ****************************************
`define DRG_WR_IDLE_BYTE 8'h00
`define DRG_SHIFT_RESET 8'h00

`endif

// *** drg_pkg.sv ***
// Purpose: Types shared by the read gate supervisor
// Assumes: Nothing
// Notes: Constants live in drg_regs.svh
package drg_pkg;

    typedef enum logic [2:0] {
        RG_OFF,
        RG_ZERO,
        RG_NZ,
        RG_SYNC,
        RG_HOLD
    } drg_gate_state_t;

    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_SEARCH
    } drg_cmd_state_t;

endpackage

// *** drg_sync.sv ***
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a level or a toggle, stable for two destination edges
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module drg_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Data
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            q_out <= '0;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end

endmodule // drg_sync

// *** drg_drive_model.sv ***
// Purpose: Behavioural separator and drive seen from the read gate supervisor
// Assumes: Read gate is sampled on the falling link clock edge
// Notes: Clock line itself is made by the bench
`timescale 1ns/100ps
module drg_drive_model (
    // Link clock and gate
    input wire logic rclk_in,
    input wire logic rd_gate_in,
    // Scenario setup
    input wire logic [7:0] lock_zeros_in,
    input wire logic [15:0] bytes_in,
    input wire logic [4:0] nbits_in,
    input wire logic mark_en_in,
    // Pins towards the controller
    output logic nrz_rdata_out,
    output logic mark_out
);
    int pos;
    int k;

    initial begin
        nrz_rdata_out = 1'b0;
        mark_out = 1'b0;
        pos = 0;
    end

    // ****************************************
    // Lock, then data
    // ****************************************
    always @(negedge rclk_in) begin
        if (rd_gate_in !== 1'b1) begin
            pos = 0;
            nrz_rdata_out <= 1'b0;
            mark_out <= 1'b0;
        end else begin
            pos = pos + 1;
            k = pos - int'(lock_zeros_in) - 1;
            if (k >= 0 && k < int'(nbits_in)) begin
                nrz_rdata_out <= bytes_in[15 - k];
                mark_out <= mark_en_in && k < 8;
            end else begin
                nrz_rdata_out <= 1'b0;
                mark_out <= 1'b0;
            end
        end
    end
endmodule // drg_drive_model

// *** drg_read_gate_bench.sv ***
// Purpose: Self-checking bench for the read gate supervisor
// Assumes: Link clock runs free, unrelated in phase to the system clock
// Notes: Drive model supplies read data and the mark input
`timescale 1ns/100ps
module drg_read_gate_bench;
    logic clk_sys_in, resetn_in, rclk_in, start_in, sam_mode_in, index_in;
    logic [7:0] first_pattern_in, sync_byte_in, wr_byte_in, lock_zeros;
    logic [15:0] bytes;
    logic [4:0] nbits;
    logic write_en_in, wr_load_in, mark_en, busy_out, found_out, sect_not_found_out;
    logic wr_ready_out, mark_found_input_in, nrz_rdata_in, rd_gate_out;
    logic wr_gate_out, nrz_wdata_out, wclk_out;
    int fail_count, checked, wclk_n;

    // ****************************************
    // Clocks
    // ****************************************
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // reference clock runs free, one clean line with no switch glitches
    initial begin
        rclk_in = 1'b0;
        #3.3;
        forever #7.5 rclk_in = ~rclk_in;
    end
    always @(posedge wclk_out) if (wr_gate_out === 1'b1) wclk_n++;

    drg_read_gate dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .rclk_in(rclk_in),
        .start_in(start_in), .sam_mode_in(sam_mode_in), .first_pattern_in(first_pattern_in),
        .sync_byte_in(sync_byte_in), .busy_out(busy_out), .found_out(found_out),
        .sect_not_found_out(sect_not_found_out), .write_en_in(write_en_in), .wr_load_in(wr_load_in),
        .wr_byte_in(wr_byte_in), .wr_ready_out(wr_ready_out), .index_in(index_in),
        .mark_found_input_in(mark_found_input_in), .nrz_rdata_in(nrz_rdata_in),
        .rd_gate_out(rd_gate_out), .wr_gate_out(wr_gate_out), .nrz_wdata_out(nrz_wdata_out),
        .wclk_out(wclk_out));
    drg_drive_model drive (.rclk_in(rclk_in), .rd_gate_in(rd_gate_out), .lock_zeros_in(lock_zeros),
        .bytes_in(bytes), .nbits_in(nbits), .mark_en_in(mark_en), .nrz_rdata_out(nrz_rdata_in),
        .mark_out(mark_found_input_in));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Counts link edges up to the one that first samples the gate at lvl
    task automatic edges_until(input logic lvl, output int n);
        logic seen;
        n = 0;
        do begin
            @(negedge rclk_in);
            seen = rd_gate_out;
            @(posedge rclk_in);
            n++;
        end while (seen !== lvl && n < 60);
    endtask

    task automatic start_search(input logic [7:0] b0, input logic sam, input logic mark);
        // Gate and separator must settle a full off time before a new search
        repeat (24) @(negedge rclk_in);
        lock_zeros = 8'h18;
        bytes = {b0, 8'h5B};
        mark_en = mark;
        @(negedge clk_sys_in);
        first_pattern_in = 8'hA1;
        sync_byte_in = 8'h5B;
        sam_mode_in = sam;
        start_in = 1'b1;
        @(negedge clk_sys_in);
        start_in = 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 5000) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk("search end", 8'h01, {7'h00, n < 5000});
    endtask

    task automatic index_twice();
        repeat (2) begin
            @(negedge clk_sys_in);
            index_in = 1'b1;
            repeat (4) @(negedge clk_sys_in);
            index_in = 1'b0;
            repeat (4) @(negedge clk_sys_in);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_found(input logic sam, input logic mark);
        nbits = 5'h10;
        start_search(8'hA1, sam, mark);
        wait_idle();
        chk("found", 8'h01, {7'h00, found_out});
        chk("not found flag", 8'h00, {7'h00, sect_not_found_out});
        repeat (6) @(negedge rclk_in);
        chk("gate after sync", 8'h00, {7'h00, rd_gate_out});
    endtask

    task automatic s_drop(input logic [7:0] b0, input logic mark);
        int n;
        int m;
        n = 0;
        m = 0;
        nbits = 5'h10;
        start_search(b0, 1'b0, mark);
        while (nrz_rdata_in !== 1'b1 && m < 500) begin
            @(posedge rclk_in);
            m++;
        end
        edges_until(1'b0, n);
        chk("gate drop delay", 8'h13, n[7:0]);
        edges_until(1'b1, m);
        chk("gate low time", 8'h12, m[7:0]);
        index_twice();
        wait_idle();
        chk("not found flag", 8'h01, {7'h00, sect_not_found_out});
        chk("found", 8'h00, {7'h00, found_out});
    endtask

    task automatic s_all_zero();
        nbits = 5'h00;
        start_search(8'hA1, 1'b0, 1'b0);
        repeat (300) @(negedge rclk_in);
        chk("gate held", 8'h01, {7'h00, rd_gate_out});
        chk("busy held", 8'h01, {7'h00, busy_out});
        index_twice();
        wait_idle();
        chk("not found flag", 8'h01, {7'h00, sect_not_found_out});
        repeat (10) @(negedge rclk_in);
        chk("gate after abort", 8'h00, {7'h00, rd_gate_out});
    endtask

    task automatic s_write();
        int n;
        logic [15:0] seen;
        n = 0;
        seen = 16'h0000;
        @(negedge clk_sys_in);
        write_en_in = 1'b1;
        wr_byte_in = 8'hB4;
        wr_load_in = 1'b1;
        @(negedge clk_sys_in);
        wr_load_in = 1'b0;
        chk("ready after load", 8'h00, {7'h00, wr_ready_out});
        while (nrz_wdata_out !== 1'b1 && n < 80) begin
            @(negedge rclk_in);
            n++;
        end
        wclk_n = 0;
        repeat (16) begin
            seen = {seen[14:0], nrz_wdata_out};
            @(negedge rclk_in);
        end
        chk("write byte", 8'hB4, seen[15:8]);
        chk("underrun fill", 8'h00, seen[7:0]);
        chk("write clock edges", 8'h10, wclk_n[7:0]);
        chk("ready again", 8'h01, {7'h00, wr_ready_out});
        @(negedge clk_sys_in);
        write_en_in = 1'b0;
        repeat (10) @(negedge rclk_in);
        chk("write gate off", 8'h00, {7'h00, wr_gate_out});
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        resetn_in = 1'b0;
        start_in = 1'b0;
        sam_mode_in = 1'b0;
        index_in = 1'b0;
        first_pattern_in = 8'h00;
        sync_byte_in = 8'h00;
        write_en_in = 1'b0;
        wr_load_in = 1'b0;
        wr_byte_in = 8'h00;
        lock_zeros = 8'h18;
        bytes = 16'h0000;
        nbits = 5'h00;
        mark_en = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge rclk_in);
        s_found(1'b0, 1'b1);
        s_found(1'b1, 1'b0);
        s_drop(8'h96, 1'b1);
        s_drop(8'hA1, 1'b0);
        s_all_zero();
        s_write();
        print_verdict();
    end

    // Whole run needs about 12 us; this leaves a wide margin
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule // drg_read_gate_bench
